// ==== lcr_pkg.sv ====
/*
 * Constants and types for the link interface command register block:
 * offset, field positions, type codes, reset values and timing.
 * Assumes a single 100 MHz clock shared by every user of the package.
 */
package lcr_pkg;

    // ------------------------------------------------------------------
    // Register map.
    // ------------------------------------------------------------------
    localparam logic [7:0]  LCR_CMD_OFS       = 8'h02;  // Command register byte offset.
    localparam int unsigned LCR_LINKS         = 2;      // Link control copies in the block.

    // ------------------------------------------------------------------
    // Field positions shared by both layouts.
    // ------------------------------------------------------------------
    localparam int unsigned LCR_TYPE_LSB      = 13;
    localparam int unsigned LCR_DROP_BIT      = 12;
    localparam int unsigned LCR_LANE_HI_LSB   = 8;

    // Slave layout positions.
    localparam int unsigned LCR_S_BASE_LSB    = 0;
    localparam int unsigned LCR_S_COUNT_LSB   = 5;
    localparam int unsigned LCR_S_UPLINK_BIT  = 10;
    localparam int unsigned LCR_S_ROUTE_BIT   = 11;

    // Host layout positions.
    localparam int unsigned LCR_H_WARMSEL_BIT = 0;
    localparam int unsigned LCR_H_DUAL_BIT    = 1;
    localparam int unsigned LCR_H_SLOT_LSB    = 2;
    localparam int unsigned LCR_H_ORIGIN_BIT  = 7;
    localparam int unsigned LCR_H_CLOAK_BIT   = 8;
    localparam int unsigned LCR_H_FOLLOW_BIT  = 10;
    localparam int unsigned LCR_H_FAULT_BIT   = 11;

    // Bits that carry a field in each layout, type field included.
    localparam logic [15:0] LCR_S_DEFINED     = 16'hFFFF;
    localparam logic [15:0] LCR_H_DEFINED     = 16'hFDFF;

    // ------------------------------------------------------------------
    // Capability type codes.
    // ------------------------------------------------------------------
    localparam logic [2:0]  LCR_TYPE_SLAVE    = 3'h0;
    localparam logic [2:0]  LCR_TYPE_HOST     = 3'h1;
    localparam logic [4:0]  LCR_TYPE_IRQ      = 5'h10;
    localparam logic [4:0]  LCR_TYPE_REVID    = 5'h11;
    localparam logic [4:0]  LCR_TYPE_RETRY    = 5'h18;
    localparam logic [4:0]  LCR_RSVD_A_LO     = 5'h09;
    localparam logic [4:0]  LCR_RSVD_A_HI     = 5'h0F;
    localparam logic [4:0]  LCR_RSVD_B_LO     = 5'h1A;

    // ------------------------------------------------------------------
    // Reset values.
    // ------------------------------------------------------------------
    localparam logic [4:0]  LCR_ID_RST        = 5'h00;
    localparam logic        LCR_WARMSEL_RST   = 1'b1;
    localparam logic        LCR_BIT_CLR       = 1'b0;
    localparam logic [4:0]  LCR_UNIT_COUNT    = 5'h01;  // Identifiers owned by the device.

    // ------------------------------------------------------------------
    // Timing.
    // ------------------------------------------------------------------
    localparam int unsigned LCR_CLK_NS        = 10;
    localparam int unsigned LCR_STALL_LIM_US  = 100;
    localparam int unsigned LCR_STALL_LIM_CYC = LCR_STALL_LIM_US * 1000 / LCR_CLK_NS;

    // Disposition of a packet headed for one link.
    typedef enum logic [1:0] {
        LCR_FORWARD,
        LCR_REJECT,
        LCR_STALL
    } lcr_disp_t;

    // True for a five-bit type code that lies in a reserved range.
    function automatic logic lcrTypeReserved(input logic [4:0] code);
        lcrTypeReserved = (code >= LCR_RSVD_A_LO && code <= LCR_RSVD_A_HI)
                          || (code >= LCR_RSVD_B_LO);
    endfunction

endpackage

// ==== lcr_link_disposition.sv ====
/*
 * Per-link packet disposition: forward, reject or stall, with a stall
 * watchdog. Assumes its status inputs come from logic on the same clock.
 */
`timescale 1ns/100ps
module lcr_link_disposition
    import lcr_pkg::*;
#(
    parameter int unsigned STALL_LIMIT = LCR_STALL_LIM_CYC
) (
    input  wire logic      clk,           // System clock.
    input  wire logic      reset_n,       // Asynchronous cold reset, active low.
    input  wire logic      chainTerm,     // Link is marked as chain end.
    input  wire logic      initDone,      // Link initialisation complete.
    input  wire logic      dropUninit,    // Reject instead of stalling.
    output lcr_disp_t      disposition,   // Registered disposition.
    output logic           stallTimeout   // Stall lasted past the limit.
);

    lcr_disp_t   disp_q,   disp_d;
    logic [15:0] stallCnt_q, stallCnt_d;
    logic        tmo_q,    tmo_d;

    // Decide the disposition and count how long a stall lasts.
    always_comb begin
        if (chainTerm) begin
            disp_d = LCR_REJECT;
        end else if (initDone) begin
            disp_d = LCR_FORWARD;
        end else if (dropUninit) begin
            disp_d = LCR_REJECT;
        end else begin
            disp_d = LCR_STALL;
        end
        stallCnt_d = 16'h0000;
        tmo_d      = 1'b0;
        if (disp_d == LCR_STALL) begin
            tmo_d = tmo_q || (stallCnt_q == 16'(STALL_LIMIT - 1));
            if (!tmo_d) begin
                stallCnt_d = stallCnt_q + 16'h0001;
            end
        end
    end

    // Register the disposition and the watchdog state.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            disp_q     <= LCR_STALL;
            stallCnt_q <= 16'h0000;
            tmo_q      <= 1'b0;
        end else begin
            disp_q     <= disp_d;
            stallCnt_q <= stallCnt_d;
            tmo_q      <= tmo_d;
        end
    end

    assign disposition  = disp_q;
    assign stallTimeout = tmo_q;

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_chain_end_reject: assert property (chainTerm |=> disposition == LCR_REJECT)
        else $error("Chain end did not reject.");
    a_drop_uninit: assert property (!chainTerm && !initDone && dropUninit
        |=> disposition == LCR_REJECT)
        else $error("Uninitialised link not rejected with drop set.");
    a_stall_hold: assert property (!chainTerm && !initDone && !dropUninit
        |=> disposition == LCR_STALL)
        else $error("Uninitialised link did not stall.");

endmodule

// ==== lcr_command_reg.sv ====
/*
 * Command register of a link interface capability block, slave or host
 * layout chosen by a parameter, with its routing and reset side effects.
 * Assumes configuration accesses, link status and the warm reset request
 * all arrive synchronous to clk; reset_n is the cold reset.
 */
`timescale 1ns/100ps
module lcr_command_reg
    import lcr_pkg::*;
#(
    parameter bit          LAYOUT_HOST   = 1'b0,              // Host layout when set.
    parameter bit          TWO_LINKS     = 1'b1,              // Slave has both links.
    parameter bit          DOUBLE_HOSTED = 1'b1,              // Host shares its chain.
    parameter int unsigned STALL_LIMIT   = LCR_STALL_LIM_CYC  // Stall watchdog in cycles.
) (
    input  wire logic        clk,             // System clock, 100 MHz.
    input  wire logic        reset_n,         // Asynchronous cold reset, active low.
    input  wire logic        warmReset,       // Synchronous warm reset request.
    input  wire logic [7:0]  cfgAddr,         // Byte offset in the capability block.
    input  wire logic        cfgWrite,        // Configuration write strobe.
    input  wire logic        cfgRead,         // Configuration read strobe.
    input  wire logic [1:0]  cfgByteEn,       // Byte lanes of the write.
    input  wire logic [15:0] cfgWrData,       // Write data.
    input  wire logic        cfgLink,         // Link of a write, or chain side for host.
    output logic      [15:0] cfgRdData,       // Read data, registered.
    output logic             cfgRdValid,      // Read data valid pulse.
    input  wire logic [4:0]  reqUnitId,       // Identifier of an incoming packet.
    output logic             unitIdHit,       // Identifier belongs to this device.
    input  wire logic [1:0]  linkInitDone,    // Per-link initialisation complete.
    input  wire logic [1:0]  linkChainTerminated, // Per-link chain end flag.
    output lcr_disp_t        linkDisp [LCR_LINKS], // Per-link packet disposition.
    output logic      [1:0]  linkStallTimeout, // Per-link stall watchdog fired.
    output logic      [4:0]  firstNodeId,     // Base identifier in use.
    output logic             upstreamLink,    // Link toward the master host.
    output logic             routeAway,       // Send requests away from host.
    output logic             respBridgeFlag,  // Mark responses as from bridge.
    output logic             hostRouting,     // Use host routing rules.
    output logic      [4:0]  hostSlot,        // Device number answered from chain.
    output logic             chainCfgHidden,  // Chain config accesses hidden.
    input  wire logic        farHostEocErr,   // Far host packet hit chain end.
    input  wire logic        secBusReset,     // Secondary bus reset control level.
    output logic             powerGoodLine,   // Power good to the chain.
    output logic             chainReset_n     // Chain reset, active low.
);

    // ------------------------------------------------------------------
    // Decode.
    // ------------------------------------------------------------------

    logic cmdHit;
    logic wrLo;
    logic wrHi;
    logic cmdWrite;

    // A write lands when the offset matches; lanes select the bytes.
    assign cmdHit   = (cfgAddr == LCR_CMD_OFS);
    assign cmdWrite = cfgWrite && cmdHit;
    assign wrLo     = cmdWrite && cfgByteEn[0];
    assign wrHi     = cmdWrite && cfgByteEn[1];

    // ------------------------------------------------------------------
    // Command register state.
    // ------------------------------------------------------------------

    logic [4:0] baseId_q,   baseId_d;
    logic       upLink_q,   upLink_d;
    logic       route_q,    route_d;
    logic       drop_q,     drop_d;
    logic       warmSel_q,  warmSel_d;
    logic       dual_q,     dual_d;
    logic [4:0] slot_q,     slot_d;
    logic       cloak_q,    cloak_d;
    logic       follow_q,   follow_d;
    logic       followOn_q, followOn_d;
    logic       fault_q,    fault_d;

    // Next values: writes first, then hardware events, then warm reset.
    always_comb begin
        baseId_d   = baseId_q;
        upLink_d   = upLink_q;
        route_d    = route_q;
        drop_d     = drop_q;
        warmSel_d  = warmSel_q;
        dual_d     = dual_q;
        slot_d     = slot_q;
        cloak_d    = cloak_q;
        follow_d   = follow_q;
        followOn_d = followOn_q;
        fault_d    = fault_q;
        if (!LAYOUT_HOST) begin
            if (wrLo) begin
                baseId_d = cfgWrData[LCR_S_BASE_LSB +: 5];
            end
            if (cmdWrite && TWO_LINKS) begin
                upLink_d = cfgLink;
            end
            if (wrHi && TWO_LINKS) begin
                route_d = cfgWrData[LCR_S_ROUTE_BIT];
            end
        end else begin
            if (wrLo) begin
                warmSel_d = cfgWrData[LCR_H_WARMSEL_BIT];
                dual_d    = DOUBLE_HOSTED && cfgWrData[LCR_H_DUAL_BIT];
                slot_d    = cfgWrData[LCR_H_SLOT_LSB +: 5];
            end
            if (wrHi && DOUBLE_HOSTED) begin
                cloak_d  = cfgWrData[LCR_H_CLOAK_BIT];
                follow_d = cfgWrData[LCR_H_FOLLOW_BIT];
            end
            if (wrHi && cfgWrData[LCR_H_FAULT_BIT]) begin
                fault_d = LCR_BIT_CLR;
            end
            if (farHostEocErr) begin
                fault_d = 1'b1;
            end
        end
        if (wrHi) begin
            drop_d = cfgWrData[LCR_DROP_BIT];
        end
        if (warmReset) begin
            baseId_d   = LCR_ID_RST;
            upLink_d   = LCR_BIT_CLR;
            route_d    = LCR_BIT_CLR;
            warmSel_d  = LCR_WARMSEL_RST;
            dual_d     = LCR_BIT_CLR;
            cloak_d    = LCR_BIT_CLR;
            followOn_d = follow_q;
        end
    end

    // Cold reset restores every field; warm fields follow in the comb.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            baseId_q   <= LCR_ID_RST;
            upLink_q   <= LCR_BIT_CLR;
            route_q    <= LCR_BIT_CLR;
            drop_q     <= LCR_BIT_CLR;
            warmSel_q  <= LCR_WARMSEL_RST;
            dual_q     <= LCR_BIT_CLR;
            slot_q     <= LCR_ID_RST;
            cloak_q    <= LCR_BIT_CLR;
            follow_q   <= LCR_BIT_CLR;
            followOn_q <= LCR_BIT_CLR;
            fault_q    <= LCR_BIT_CLR;
        end else begin
            baseId_q   <= baseId_d;
            upLink_q   <= upLink_d;
            route_q    <= route_d;
            drop_q     <= drop_d;
            warmSel_q  <= warmSel_d;
            dual_q     <= dual_d;
            slot_q     <= slot_d;
            cloak_q    <= cloak_d;
            follow_q   <= follow_d;
            followOn_q <= followOn_d;
            fault_q    <= fault_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path and reset sequencing.
    // ------------------------------------------------------------------

    logic [15:0] view;
    logic [15:0] rdData_q, rdData_d;
    logic        rdValid_q, rdValid_d;
    logic        pgood_q,  pgood_d;
    logic        chRst_q,  chRst_d;

    // Assemble the visible word; bits left unassigned stay zero.
    always_comb begin
        view = 16'h0000;
        if (!LAYOUT_HOST) begin
            view[LCR_TYPE_LSB +: 3]      = LCR_TYPE_SLAVE;
            view[LCR_S_BASE_LSB +: 5]    = baseId_q;
            view[LCR_S_COUNT_LSB +: 5]   = LCR_UNIT_COUNT;
            view[LCR_S_UPLINK_BIT]       = upLink_q;
            view[LCR_S_ROUTE_BIT]        = route_q;
        end else begin
            view[LCR_TYPE_LSB +: 3]      = LCR_TYPE_HOST;
            view[LCR_H_WARMSEL_BIT]      = warmSel_q;
            view[LCR_H_DUAL_BIT]         = dual_q;
            view[LCR_H_SLOT_LSB +: 5]    = slot_q;
            view[LCR_H_ORIGIN_BIT]       = DOUBLE_HOSTED && cfgLink;
            view[LCR_H_CLOAK_BIT]        = !DOUBLE_HOSTED || cloak_q;
            view[LCR_H_FOLLOW_BIT]       = follow_q;
            view[LCR_H_FAULT_BIT]        = fault_q;
        end
        view[LCR_DROP_BIT] = drop_q;
        rdData_d  = (cfgRead && cmdHit) ? view : 16'h0000;
        rdValid_d = cfgRead;
        // A cold secondary reset drops power good with the chain reset.
        pgood_d   = !(LAYOUT_HOST && secBusReset && !warmSel_q);
        chRst_d   = !secBusReset;
    end

    // Register read data and the reset pins.
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdData_q  <= 16'h0000;
            rdValid_q <= 1'b0;
            pgood_q   <= 1'b1;
            chRst_q   <= 1'b1;
        end else begin
            rdData_q  <= rdData_d;
            rdValid_q <= rdValid_d;
            pgood_q   <= pgood_d;
            chRst_q   <= chRst_d;
        end
    end

    assign cfgRdData     = rdData_q;
    assign cfgRdValid    = rdValid_q;
    assign powerGoodLine = pgood_q;
    assign chainReset_n  = chRst_q;

    // ------------------------------------------------------------------
    // Identity and routing outputs.
    // ------------------------------------------------------------------

    logic [4:0] idOffset;

    // A follower host uses its slot as base and routes as an ordinary node.
    assign firstNodeId    = !LAYOUT_HOST ? baseId_q
                          : (followOn_q ? slot_q : LCR_ID_RST);
    assign respBridgeFlag = LAYOUT_HOST && !followOn_q;
    assign hostRouting    = LAYOUT_HOST && !followOn_q;
    assign upstreamLink   = upLink_q;
    assign routeAway      = route_q;
    assign hostSlot       = slot_q;
    assign chainCfgHidden = LAYOUT_HOST && (!DOUBLE_HOSTED || cloak_q);

    // Claim identifiers from base up to base plus count minus one.
    assign idOffset  = reqUnitId - firstNodeId;
    assign unitIdHit = LAYOUT_HOST ? (reqUnitId == firstNodeId)
                                   : (idOffset < LCR_UNIT_COUNT);

    // ------------------------------------------------------------------
    // Per-link disposition.
    // ------------------------------------------------------------------

    for (genvar i = 0; i < LCR_LINKS; i++) begin : g_link
        lcr_link_disposition #(
            .STALL_LIMIT (STALL_LIMIT)
        ) u_disp (
            .clk          (clk),
            .reset_n      (reset_n),
            .chainTerm    (linkChainTerminated[i]),
            .initDone     (linkInitDone[i]),
            .dropUninit   (drop_q),
            .disposition  (linkDisp[i]),
            .stallTimeout (linkStallTimeout[i])
        );
    end

    // ------------------------------------------------------------------
    // Checks.
    // ------------------------------------------------------------------

    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_type_field: assert property (cfgRead && cmdHit |=>
        cfgRdData[15:13] == (LAYOUT_HOST ? LCR_TYPE_HOST : LCR_TYPE_SLAVE))
        else $error("Type field reads wrong.");
    a_type_legal: assert property (cfgRdValid |->
        !lcrTypeReserved({cfgRdData[15:13], 2'b00}))
        else $error("Type field reads a reserved code.");
    a_reserved_zero: assert property (cfgRdValid |->
        (cfgRdData & ~(LAYOUT_HOST ? LCR_H_DEFINED : LCR_S_DEFINED)) == 16'h0000)
        else $error("Reserved bit reads nonzero.");
    a_unmapped_zero: assert property (cfgRead && !cmdHit |=> cfgRdData == 16'h0000)
        else $error("Unmapped offset reads nonzero.");
    a_uplink_load: assert property (cmdWrite && !warmReset && !LAYOUT_HOST && TWO_LINKS
        |=> upstreamLink == $past(cfgLink))
        else $error("Link pointer not loaded by write.");
    a_warm_clear: assert property (warmReset |=> firstNodeId == LCR_ID_RST || LAYOUT_HOST)
        else $error("Base identifier survived warm reset.");
    a_route_single: assert property (!TWO_LINKS |-> !routeAway)
        else $error("Route bit set on single link.");
    a_drop_cold: assert property (warmReset && !wrHi |=> $stable(drop_q))
        else $error("Drop bit changed by warm reset.");
    a_pgood_low: assert property (LAYOUT_HOST && secBusReset && !warmSel_q
        |=> !powerGoodLine && !chainReset_n)
        else $error("Cold secondary reset missing.");
    a_fault_set: assert property (LAYOUT_HOST && farHostEocErr |=> fault_q)
        else $error("Far fault not set.");
    a_fault_hold: assert property (fault_q && !(wrHi && cfgWrData[LCR_H_FAULT_BIT])
        |=> fault_q)
        else $error("Far fault lost without clear.");
    a_follow_late: assert property (!warmReset |=> $stable(respBridgeFlag))
        else $error("Follower mode changed without warm reset.");

endmodule

// ==== testbench.sv ====
/*
 * Self-checking bench for the command register in both layouts.
 * Assumes lcr_pkg and lcr_command_reg are compiled first.
 */
`timescale 1ns/100ps
module testbench
    import lcr_pkg::*;
;
    logic        clk, reset_n, warmReset, cfgWrite, cfgRead, cfgLink, rdValid, hit;
    logic        tgtHost, hWrite, hRead, hRdValid, hBridge, hHostRt, hHidden;
    logic        pgood, chRstN, farErr, secRst, upL, rtA;
    logic [4:0]  hFirst, hSlot, first;
    logic [15:0] hRdData;
    logic [15:0] hExpQ [$];
    logic [7:0]  cfgAddr;
    logic [1:0]  cfgByteEn, initDone, chainTerm, stallTo;
    logic [15:0] cfgWrData, rdData;
    logic [4:0]  reqUnitId, base;
    lcr_disp_t   disp [LCR_LINKS];
    int          err_count, checks_done;
    logic [15:0] expQ [$];

    // ------------------------------------------------------------------
    // Design under test, stall limit shortened to 8 cycles.
    // ------------------------------------------------------------------
    lcr_command_reg #(.STALL_LIMIT(8)) dut (.clk(clk), .reset_n(reset_n),
        .warmReset(warmReset), .cfgAddr(cfgAddr), .cfgWrite(cfgWrite), .cfgRead(cfgRead),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgLink(cfgLink),
        .cfgRdData(rdData), .cfgRdValid(rdValid), .reqUnitId(reqUnitId), .unitIdHit(hit),
        .linkInitDone(initDone), .linkChainTerminated(chainTerm), .linkDisp(disp),
        .linkStallTimeout(stallTo), .firstNodeId(first), .upstreamLink(upL), .routeAway(rtA),
        .respBridgeFlag(), .hostRouting(), .hostSlot(), .chainCfgHidden(),
        .farHostEocErr(1'b0), .secBusReset(1'b0), .powerGoodLine(), .chainReset_n());

    // Host layout copy on its own strobes, far error and secondary reset; other inputs are shared.
    lcr_command_reg #(.LAYOUT_HOST(1'b1), .STALL_LIMIT(8)) dutHost (.clk(clk), .reset_n(reset_n),
        .warmReset(warmReset), .cfgAddr(cfgAddr), .cfgWrite(hWrite), .cfgRead(hRead),
        .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgLink(cfgLink),
        .cfgRdData(hRdData), .cfgRdValid(hRdValid), .reqUnitId(reqUnitId), .unitIdHit(),
        .linkInitDone(initDone), .linkChainTerminated(chainTerm), .linkDisp(),
        .linkStallTimeout(), .firstNodeId(hFirst), .upstreamLink(), .routeAway(),
        .respBridgeFlag(hBridge), .hostRouting(hHostRt), .hostSlot(hSlot),
        .chainCfgHidden(hHidden), .farHostEocErr(farErr), .secBusReset(secRst),
        .powerGoodLine(pgood), .chainReset_n(chRstN));

    // Free-running 100 MHz clock.
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Compares one value and reports a difference at once.
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then stops.
    task automatic summarize();
        if (expQ.size() != 0 || hExpQ.size() != 0) err_count++;
        $display("checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // One write cycle to the command register.
    task automatic wr(input logic [15:0] d, input logic [1:0] be, input logic lk);
        @(posedge clk);
        if (tgtHost) hWrite <= 1'b1;
        else cfgWrite <= 1'b1;
        cfgWrData <= d;
        cfgByteEn <= be;
        cfgLink <= lk;
        cfgAddr <= 8'h02;
        @(posedge clk);
        cfgWrite <= 1'b0;
        hWrite <= 1'b0;
    endtask

    // One warm reset pulse, then the registered outputs settle.
    task automatic warm();
        @(posedge clk);
        warmReset <= 1'b1;
        @(posedge clk);
        warmReset <= 1'b0;
        #1;
    endtask

    // One read cycle; the expected word waits in the queue.
    task automatic rd(input logic [7:0] a, input logic [15:0] e);
        @(posedge clk);
        if (tgtHost) hRead <= 1'b1;
        else cfgRead <= 1'b1;
        cfgAddr <= a;
        if (tgtHost) hExpQ.push_back(e);
        else expQ.push_back(e);
        @(posedge clk);
        cfgRead <= 1'b0;
        hRead <= 1'b0;
    endtask

    // Identifier match for one requested unit.
    task automatic idh(input logic [4:0] id, input logic e);
        @(posedge clk);
        reqUnitId <= id;
        @(posedge clk);
        #1 check({15'h0000, hit}, {15'h0000, e});
    endtask

    // Link status applied to both links, disposition seen on link 0.
    task automatic dsp(input logic t, input logic i, input lcr_disp_t e);
        @(posedge clk);
        chainTerm <= {2{t}};
        initDone <= {2{i}};
        repeat (2) @(posedge clk);
        #1 check({14'h0000, disp[0]}, {14'h0000, e});
    endtask

    // Read data is matched against the oldest expectation.
    always @(posedge clk) begin
        if (rdValid === 1'b1) check(rdData, expQ.size() ? expQ.pop_front() : 16'hXXXX);
    end

    // Host read data is matched against its own queue.
    always @(posedge clk) begin
        if (hRdValid === 1'b1) check(hRdData, hExpQ.size() ? hExpQ.pop_front() : 16'hXXXX);
    end

    // Watchdog against a hung run.
    initial begin
        #20000;
        err_count++;
        summarize();
    end

    // ------------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------------
    initial begin
        {reset_n, warmReset, cfgWrite, cfgRead, cfgLink, cfgByteEn} = '0;
        {cfgAddr, cfgWrData, reqUnitId, initDone, chainTerm} = '0;
        {tgtHost, hWrite, hRead, farErr, secRst} = '0;
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        void'($urandom(86115));
        rd(8'h02, 16'h0020);
        wr(16'hFFFF, 2'b11, 1'b1);
        rd(8'h02, 16'h1C3F);
        #1 check({9'h000, upL, rtA, first}, 16'h007F);
        wr(16'h0000, 2'b01, 1'b0);
        rd(8'h02, 16'h1820);
        rd(8'h04, 16'h0000);
        base = 5'($urandom % 31);
        wr({11'h000, base}, 2'b01, 1'b0);
        rd(8'h02, {8'h18, 3'h1, base});
        idh(base, 1'b1);
        idh(base + 5'h01, 1'b0);
        warm();
        rd(8'h02, 16'h1020);
        dsp(1'b0, 1'b0, LCR_REJECT);
        dsp(1'b1, 1'b1, LCR_REJECT);
        dsp(1'b0, 1'b1, LCR_FORWARD);
        wr(16'h0000, 2'b11, 1'b0);
        dsp(1'b0, 1'b0, LCR_STALL);
        repeat (10) @(posedge clk);
        #1 check({15'h0000, stallTo[0]}, 16'h0001);
        tgtHost = 1'b1;
        rd(8'h02, 16'h2001);
        wr(16'hFFFF, 2'b11, 1'b1);
        rd(8'h02, 16'h35FF);
        #1 check({3'h0, hSlot, hFirst, hHidden, hBridge, hHostRt}, 16'h1F07);
        warm();
        check({3'h0, hSlot, hFirst, hHidden, hBridge, hHostRt}, 16'h1FF8);
        @(posedge clk);
        farErr <= 1'b1;
        @(posedge clk);
        farErr <= 1'b0;
        rd(8'h02, 16'h3CFD);
        wr(16'h0800, 2'b10, 1'b0);
        rd(8'h02, 16'h207D);
        wr(16'h007C, 2'b01, 1'b0);
        secRst <= 1'b1;
        repeat (2) @(posedge clk);
        #1 check({14'h0000, pgood, chRstN}, 16'h0000);
        @(posedge clk);
        secRst <= 1'b0;
        repeat (2) @(posedge clk);
        #1 check({14'h0000, pgood, chRstN}, 16'h0003);
        summarize();
    end
endmodule
